// >>> design/mpo_pkg.sv
// shared constants for the motor pwm option block
package mpo_pkg;

  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int unsigned ADDR_W         = 28;
  localparam int unsigned DATA_W         = 8;
  localparam logic [27:0] OFS_CULL_OPT   = 28'hFFFF620;
  localparam logic [27:0] OFS_DT_ADC_OPT = 28'hFFFF621;
  localparam logic [7:0]  RST_CULL_OPT   = 8'h00;
  localparam logic [7:0]  RST_DT_ADC_OPT = 8'h00;
  localparam logic [7:0]  RD_IDLE        = 8'h00;
  // bit 5 of the cull option is unused and reads as zero
  localparam logic [7:0]  CULL_OPT_MASK  = 8'hDF;

  // ****************************************************************
  // interrupt_cull_option fields
  // ****************************************************************
  localparam int unsigned CREST_USE_BIT  = 7;
  localparam int unsigned VALLEY_USE_BIT = 6;
  localparam int unsigned CULL_LSB       = 0;
  localparam int unsigned CULL_MSB       = 4;
  localparam int unsigned CULL_W         = 5;
  localparam logic [4:0]  CULL_CLEAR     = 5'h00;
  localparam logic [4:0]  CULL_STEP      = 5'h01;

  // ****************************************************************
  // deadtime_adc_trigger_option fields
  // ****************************************************************
  localparam int unsigned XFER_CULL_BIT  = 7;
  localparam int unsigned DT_MODE_BIT    = 6;
  localparam int unsigned DIR_CMP1_BIT   = 5;
  localparam int unsigned DIR_CMP0_BIT   = 4;
  localparam int unsigned EN_CMP1_BIT    = 3;
  localparam int unsigned EN_CMP0_BIT    = 2;
  localparam int unsigned EN_CREST_BIT   = 1;
  localparam int unsigned EN_VALLEY_BIT  = 0;

  // ****************************************************************
  // dead-time counters
  // ****************************************************************
  localparam int unsigned PHASES         = 3;
  localparam int unsigned DT_W           = 10;
  localparam logic [9:0]  DT_CLEAR       = 10'h000;
  localparam logic [9:0]  DT_STEP        = 10'h001;

endpackage

// >>> design/mpo_deadtime_ctr.sv
// one 10-bit dead-time counter for a single pwm phase
`timescale 1ns/1ps
module mpo_deadtime_ctr (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             count_en,
  input  wire logic             run,
  input  wire logic             narrow_mode,
  input  wire logic             phase_in,
  input  wire logic [9:0]       compare,
  output logic                  busy,
  output logic                  count_down,
  output logic [9:0]            count
);

  // ****************************************************************
  // phase edge detect
  // ****************************************************************
  logic phase_q;
  logic edge_hit;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= phase_in;
    end
  end

  assign edge_hit = run && (phase_in != phase_q);

  // ****************************************************************
  // counter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      busy       <= 1'b0;
      count_down <= 1'b0;
      count      <= mpo_pkg::DT_CLEAR;
    end else if (edge_hit) begin
      if (busy && narrow_mode) begin
        // pulse narrower than dead time: reverse instead of restart
        count_down <= !count_down;
      end else begin
        busy       <= 1'b1;
        count_down <= 1'b0;
        count      <= mpo_pkg::DT_CLEAR;
      end
    end else if (busy && count_en) begin
      if (!count_down) begin
        if (count == compare) begin
          busy <= 1'b0;
        end else begin
          count <= count + mpo_pkg::DT_STEP;
        end
      end else if (count == mpo_pkg::DT_CLEAR) begin
        busy       <= 1'b0;
        count_down <= 1'b0;
      end else begin
        count <= count - mpo_pkg::DT_STEP;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  restart_clear_a: assert property (@(posedge clk) disable iff (rst)
    edge_hit && busy && !narrow_mode |=> busy && !count_down && count == 10'h000)
    else $error("restart did not clear dead-time counter");

  narrow_down_a: assert property (@(posedge clk) disable iff (rst)
    edge_hit && busy && narrow_mode && !count_down |=> busy && count_down)
    else $error("narrow mode did not turn counter down");

  match_stop_a: assert property (@(posedge clk) disable iff (rst)
    run && !edge_hit && busy && !count_down && count_en && count == compare
    |=> !busy)
    else $error("dead-time counter ran past compare");

endmodule

// >>> design/mpo_top.sv
// motor pwm option logic: interrupt and transfer culling, dead time, adc trigger
// Function
// - cull option register is 8-bit read/write, reset to zero.
// - cull option writes accepted while running, immediate or batch per mode.
// - crest interrupt counted for culling only when its use bit is set.
// - valley interrupt counted for culling only when its use bit is set.
// - cull setting N passes one of every N+1 counted events.
// - second option writable while running, dead-time mode bit held then.
// - transfer at every crest and valley, or culled like interrupts.
// - mode 0: narrow pulse clears dead-time counter and restarts count up.
// - mode 1: narrow pulse makes dead-time counter count down.
// - bit 5 picks counter direction qualifying second companion compare trigger.
// - bit 4 picks counter direction qualifying first companion compare trigger.
// - bits 3 to 0 enable adc trigger per source.
// - culled interrupt and batch transfer occur on the same event.
// - second option register is 8-bit read/write, reset to zero.
// - rewrite mode 0 is batch by transfer, 1 updates immediately.
// - 10-bit dead-time counter starts on phase edge, stops at compare.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module mpo_top (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [27:0]      addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  input  wire logic             timer_run_enable,
  input  wire logic             rewrite_mode_select,
  input  wire logic             count_en,
  input  wire logic             crest_irq,
  input  wire logic             valley_irq,
  input  wire logic             companion_compare0_irq,
  input  wire logic             companion_compare1_irq,
  input  wire logic [2:0]       pwm_phase_output,
  input  wire logic [9:0]       deadtime_compare,
  output logic                  crest_irq_out,
  output logic                  valley_irq_out,
  output logic                  transfer_strobe,
  output logic                  adc_trigger_out,
  output logic      [2:0]       deadtime_busy,
  output logic      [2:0]       deadtime_down
);

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic       wr_cull;
  logic       wr_dt;
  logic       imm_wr;
  logic [7:0] cull_wdata;

  assign wr_cull    = wr && (addr == mpo_pkg::OFS_CULL_OPT);
  assign wr_dt      = wr && (addr == mpo_pkg::OFS_DT_ADC_OPT);
  // a stopped timer has no transfer to wait for
  assign imm_wr     = rewrite_mode_select || !timer_run_enable;
  assign cull_wdata = wdata & mpo_pkg::CULL_OPT_MASK;

  // ****************************************************************
  // interrupt_cull_option: software copy, pending flag, active copy
  // ****************************************************************
  logic [7:0] cull_sw_q;
  logic [7:0] cull_act_q;
  logic       pend_q;
  logic       xfer_evt;

  always_ff @(posedge clk) begin
    if (rst) begin
      cull_sw_q <= mpo_pkg::RST_CULL_OPT;
    end else if (wr_cull) begin
      cull_sw_q <= cull_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (wr_cull) begin
      // a new batch write wins over a transfer in the same cycle
      pend_q <= !imm_wr;
    end else if (xfer_evt || !timer_run_enable) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cull_act_q <= mpo_pkg::RST_CULL_OPT;
    end else if (wr_cull && imm_wr) begin
      cull_act_q <= cull_wdata;
    end else if (pend_q && (xfer_evt || !timer_run_enable)) begin
      cull_act_q <= cull_sw_q;
    end
  end

  // ****************************************************************
  // deadtime_adc_trigger_option
  // ****************************************************************
  logic [7:0] dt_opt_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      dt_opt_q <= mpo_pkg::RST_DT_ADC_OPT;
    end else if (wr_dt) begin
      dt_opt_q <= wdata;
      if (timer_run_enable) begin
        // mode bit would upset counters already running
        dt_opt_q[mpo_pkg::DT_MODE_BIT] <= dt_opt_q[mpo_pkg::DT_MODE_BIT];
      end
    end
  end

  // ****************************************************************
  // field views
  // ****************************************************************
  logic       crest_use;
  logic       valley_use;
  logic [4:0] cull_n;
  logic       xfer_cull;
  logic       dt_mode;

  assign crest_use  = cull_act_q[mpo_pkg::CREST_USE_BIT];
  assign valley_use = cull_act_q[mpo_pkg::VALLEY_USE_BIT];
  assign cull_n     = cull_act_q[mpo_pkg::CULL_MSB:mpo_pkg::CULL_LSB];
  assign xfer_cull  = dt_opt_q[mpo_pkg::XFER_CULL_BIT];
  assign dt_mode    = dt_opt_q[mpo_pkg::DT_MODE_BIT];

  // ****************************************************************
  // culling
  // ****************************************************************
  logic       crest_ev;
  logic       valley_ev;
  logic       cnt_ev;
  logic       hit;
  logic [4:0] cull_cnt_q;

  assign crest_ev  = timer_run_enable && crest_irq;
  assign valley_ev = timer_run_enable && valley_irq;
  assign cnt_ev    = (crest_ev && crest_use) || (valley_ev && valley_use);
  // >= so a setting lowered mid-run does not wait for a wrap
  assign hit       = cnt_ev && (cull_cnt_q >= cull_n);
  assign xfer_evt  = xfer_cull ? hit : (crest_ev || valley_ev);

  always_ff @(posedge clk) begin
    if (rst || !timer_run_enable) begin
      cull_cnt_q <= mpo_pkg::CULL_CLEAR;
    end else if (hit) begin
      cull_cnt_q <= mpo_pkg::CULL_CLEAR;
    end else if (cnt_ev) begin
      cull_cnt_q <= cull_cnt_q + mpo_pkg::CULL_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crest_irq_out   <= 1'b0;
      valley_irq_out  <= 1'b0;
      transfer_strobe <= 1'b0;
    end else begin
      crest_irq_out   <= hit && crest_ev && crest_use;
      valley_irq_out  <= hit && valley_ev && valley_use;
      transfer_strobe <= xfer_evt;
    end
  end

  // ****************************************************************
  // dead-time counters
  // ****************************************************************
  logic [9:0] dt_count [mpo_pkg::PHASES];

  for (genvar p = 0; p < mpo_pkg::PHASES; p++) begin : g_dt
    mpo_deadtime_ctr u_dt (
      .clk        (clk),
      .rst        (rst),
      .count_en   (count_en),
      .run        (timer_run_enable),
      .narrow_mode(dt_mode),
      .phase_in   (pwm_phase_output[p]),
      .compare    (deadtime_compare),
      .busy       (deadtime_busy[p]),
      .count_down (deadtime_down[p]),
      .count      (dt_count[p])
    );

    dt_bound_a: assert property (@(posedge clk) disable iff (rst)
      deadtime_busy[p] |-> dt_count[p] <= deadtime_compare)
      else $error("dead-time count beyond compare");
  end

  // ****************************************************************
  // adc trigger
  // ****************************************************************
  logic cmp0_ok;
  logic cmp1_ok;
  logic adc_ev;

  // first phase counter direction qualifies companion compares
  assign cmp0_ok = deadtime_down[0] == dt_opt_q[mpo_pkg::DIR_CMP0_BIT];
  assign cmp1_ok = deadtime_down[0] == dt_opt_q[mpo_pkg::DIR_CMP1_BIT];
  assign adc_ev  = timer_run_enable && (
      (dt_opt_q[mpo_pkg::EN_VALLEY_BIT] && valley_irq) ||
      (dt_opt_q[mpo_pkg::EN_CREST_BIT] && crest_irq) ||
      (dt_opt_q[mpo_pkg::EN_CMP0_BIT] && companion_compare0_irq && cmp0_ok) ||
      (dt_opt_q[mpo_pkg::EN_CMP1_BIT] && companion_compare1_irq && cmp1_ok));

  always_ff @(posedge clk) begin
    if (rst) begin
      adc_trigger_out <= 1'b0;
    end else begin
      adc_trigger_out <= adc_ev;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= mpo_pkg::RD_IDLE;
    end else if (rd && addr == mpo_pkg::OFS_CULL_OPT) begin
      rdata <= cull_sw_q;
    end else if (rd && addr == mpo_pkg::OFS_DT_ADC_OPT) begin
      rdata <= dt_opt_q;
    end else begin
      rdata <= mpo_pkg::RD_IDLE;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_batch_wr;
    wr_cull && !imm_wr;
  endsequence

  sequence s_apply;
    pend_q && xfer_evt && !wr_cull;
  endsequence

  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> cull_sw_q == 8'h00 && cull_act_q == 8'h00 && dt_opt_q == 8'h00)
    else $error("option registers not cleared by reset");

  read_back_a: assert property (
    rd && addr == mpo_pkg::OFS_CULL_OPT |=> rdata == $past(cull_sw_q)
    ##1 (rdata == mpo_pkg::RD_IDLE || $past(rd)))
    else $error("cull option read data wrong");

  immediate_wr_a: assert property (
    wr_cull && rewrite_mode_select |=> cull_act_q == ($past(wdata) & mpo_pkg::CULL_OPT_MASK))
    else $error("anytime write did not apply");

  batch_apply_a: assert property (
    s_batch_wr ##1 s_apply |=> cull_act_q == $past(cull_sw_q))
    else $error("batch write not applied at transfer");

  batch_hold_a: assert property (
    s_batch_wr ##1 (timer_run_enable && !xfer_evt && !wr_cull) |=> $stable(cull_act_q))
    else $error("batch write applied before transfer");

  mode_hold_a: assert property (
    wr_dt && timer_run_enable |=> $stable(dt_opt_q[mpo_pkg::DT_MODE_BIT]))
    else $error("dead-time mode bit changed while running");

  no_cull_a: assert property (
    cull_n == 5'h00 && crest_use && crest_ev |=> crest_irq_out)
    else $error("uncull crest interrupt lost");

  crest_unused_a: assert property (
    crest_ev && !crest_use && !valley_ev |=> !crest_irq_out && $stable(cull_cnt_q))
    else $error("unused crest interrupt was counted");

  valley_unused_a: assert property (
    valley_ev && !valley_use && !crest_ev |=> !valley_irq_out && $stable(cull_cnt_q))
    else $error("unused valley interrupt was counted");

  cull_fire_a: assert property (
    cnt_ev && cull_cnt_q >= cull_n |=> cull_cnt_q == 5'h00 && (crest_irq_out || valley_irq_out))
    else $error("cull counter did not fire and reload");

  xfer_every_a: assert property (
    !xfer_cull && (crest_ev || valley_ev) |=> transfer_strobe)
    else $error("uncull transfer missing");

  same_event_a: assert property (
    $past(xfer_cull) && !$past(rst) |-> transfer_strobe == (crest_irq_out || valley_irq_out))
    else $error("culled transfer and interrupt differ");

  adc_crest_a: assert property (
    crest_ev && dt_opt_q[mpo_pkg::EN_CREST_BIT] |=> adc_trigger_out)
    else $error("crest adc trigger missing");

  adc_cause_a: assert property (
    adc_trigger_out |-> $past(adc_ev) ##1 (!adc_trigger_out || $past(adc_ev)))
    else $error("adc trigger without qualified source");

  adc_dir_a: assert property (
    companion_compare1_irq && timer_run_enable && dt_opt_q[mpo_pkg::EN_CMP1_BIT]
    && !companion_compare0_irq && !crest_irq && !valley_irq
    |=> adc_trigger_out == $past(cmp1_ok))
    else $error("companion trigger direction qualifier wrong");

  cmp0_dir_a: assert property (
    companion_compare0_irq && timer_run_enable && dt_opt_q[mpo_pkg::EN_CMP0_BIT]
    && !companion_compare1_irq && !crest_irq && !valley_irq
    |=> adc_trigger_out == $past(cmp0_ok))
    else $error("first companion trigger direction wrong");

  adc_valley_a: assert property (
    valley_ev && dt_opt_q[mpo_pkg::EN_VALLEY_BIT] |=> adc_trigger_out)
    else $error("valley adc trigger missing");

  adc_off_a: assert property (
    dt_opt_q[3:0] == 4'h0 |=> !adc_trigger_out)
    else $error("adc trigger with all sources disabled");

  valley_no_cull_a: assert property (
    cull_n == 5'h00 && valley_use && valley_ev |=> valley_irq_out)
    else $error("uncull valley interrupt lost");

  cull_count_a: assert property (
    cnt_ev && cull_cnt_q < cull_n |=> cull_cnt_q == $past(cull_cnt_q) + 5'h01
    && !crest_irq_out && !valley_irq_out)
    else $error("culled event not counted or not masked");

  stopped_quiet_a: assert property (
    !timer_run_enable |=> cull_cnt_q == 5'h00 && !crest_irq_out && !valley_irq_out
    && !transfer_strobe && !adc_trigger_out)
    else $error("stopped timer still produced events");

  xfer_culled_a: assert property (
    xfer_cull && (crest_ev || valley_ev) && !hit |=> !transfer_strobe)
    else $error("culled transfer was issued");

  opt2_write_a: assert property (
    wr_dt && !timer_run_enable |=> dt_opt_q == $past(wdata))
    else $error("second option write lost");

  opt2_run_wr_a: assert property (
    wr_dt && timer_run_enable |=> dt_opt_q[7] == $past(wdata[7])
    && dt_opt_q[5:0] == $past(wdata[5:0]))
    else $error("second option write while running lost");

  read_opt2_a: assert property (
    rd && addr == mpo_pkg::OFS_DT_ADC_OPT |=> rdata == $past(dt_opt_q))
    else $error("second option read data wrong");

  rd_idle_a: assert property (
    !rd |=> rdata == mpo_pkg::RD_IDLE)
    else $error("read data not idle without read");

endmodule

// >>> sim/mpo_timer_model.sv
// far-side model: triangle timer events, companion compares and phase outputs
`timescale 1ns/1ps
module mpo_timer_model #(
  parameter int TOP = 12
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [4:0] width,
  output logic            count_en,
  output logic            crest_irq,
  output logic            valley_irq,
  output logic            companion_compare0_irq,
  output logic            companion_compare1_irq,
  output logic [2:0]      pwm_phase_output
);
  localparam logic [4:0] TOP_M1 = 5'(TOP - 1);
  logic [4:0] tri_q;
  logic       up_q;

  // ****************************************************************
  // triangle counter
  // ****************************************************************
  // parked at zero while stopped so every run starts with a clean rise
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      tri_q <= 5'h00;
      up_q <= 1'b1;
      crest_irq <= 1'b0;
      valley_irq <= 1'b0;
      companion_compare0_irq <= 1'b0;
      companion_compare1_irq <= 1'b0;
    end else begin
      tri_q <= up_q ? tri_q + 5'h01 : tri_q - 5'h01;
      if (up_q && tri_q == TOP_M1) begin
        up_q <= 1'b0;
      end else if (!up_q && tri_q == 5'h01) begin
        up_q <= 1'b1;
      end
      crest_irq <= up_q && tri_q == TOP_M1;
      valley_irq <= !up_q && tri_q == 5'h01;
      companion_compare0_irq <= up_q && tri_q == 5'h02;
      companion_compare1_irq <= !up_q && tri_q == 5'h04;
    end
  end

  // ****************************************************************
  // count clock and phases
  // ****************************************************************
  assign count_en = run;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pwm_phase_output[i] = run && ({3'h0, tri_q} < {3'h0, width} + 8'(i));
    end
  end
endmodule

// >>> sim/mpo_top_tb_top.sv
// self-checking bench for the motor pwm option block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module mpo_top_tb_top;
  logic       clk, rst, wr, rd, run, rms, cen, crest, valley, cc0, cc1;
  logic [27:0] addr;
  logic [7:0] wdata, rdata, got, r_act, r_pend, r_opt2;
  logic [2:0] phase, dt_busy, dt_down;
  logic [9:0] dtc;
  logic [4:0] wid, r_cnt;
  logic       o_crest, o_valley, o_xfer, o_adc, e_crest, e_valley, e_xfer, e_adc, r_pf;
  int         err_total, comparisons, cyc, bl, dn_seen;
  logic [7:0] t_cull [8] = '{8'hC0, 8'h80, 8'h41, 8'hDF, 8'hC3, 8'hC2, 8'hC1, 8'hC0};
  // transfer culling set with every nonzero count
  logic [7:0] t_opt2 [8] = '{8'h00, 8'h02, 8'h81, 8'h80, 8'h8C, 8'hBC, 8'h81, 8'h0F};

  mpo_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_run_enable(run), .rewrite_mode_select(rms), .count_en(cen),
    .crest_irq(crest), .valley_irq(valley), .companion_compare0_irq(cc0),
    .companion_compare1_irq(cc1), .pwm_phase_output(phase), .deadtime_compare(dtc),
    .crest_irq_out(o_crest), .valley_irq_out(o_valley), .transfer_strobe(o_xfer),
    .adc_trigger_out(o_adc), .deadtime_busy(dt_busy), .deadtime_down(dt_down));
  mpo_timer_model model_u (.clk(clk), .rst(rst), .run(run), .width(wid), .count_en(cen),
    .crest_irq(crest), .valley_irq(valley), .companion_compare0_irq(cc0),
    .companion_compare1_irq(cc1), .pwm_phase_output(phase));

  // ****************************************************************
  // reference of the culling, transfer and trigger outputs
  // ****************************************************************
  always @(posedge clk) begin : ref_model
    logic hit, fc, fv, ue, xev, wc;
    hit = r_cnt >= r_act[4:0];
    ue = run && ((crest && r_act[7]) || (valley && r_act[6]));
    fc = run && crest && r_act[7] && hit;
    fv = run && valley && r_act[6] && hit;
    xev = r_opt2[7] ? (fc || fv) : (run && (crest || valley));
    wc = wr && addr == mpo_pkg::OFS_CULL_OPT;
    if (rst) begin
      {e_crest, e_valley, e_xfer, e_adc, r_pf} <= 5'h00;
      {r_act, r_pend, r_opt2, r_cnt} <= 29'h0;
    end else begin
      e_crest <= fc;
      e_valley <= fv;
      e_xfer <= xev;
      e_adc <= run && ((valley && r_opt2[0]) || (crest && r_opt2[1])
        || (cc0 && r_opt2[2] && !r_opt2[4]) || (cc1 && r_opt2[3] && !r_opt2[5]));
      if (!run) r_cnt <= 5'h00;
      else if (ue) r_cnt <= hit ? 5'h00 : r_cnt + 5'h01;
      if (wc && (rms || !run)) r_act <= wdata & mpo_pkg::CULL_OPT_MASK;
      else if (wc) begin
        r_pend <= wdata & mpo_pkg::CULL_OPT_MASK;
        r_pf <= 1'b1;
      end else if (r_pf && (xev || !run)) begin
        r_act <= r_pend;
        r_pf <= 1'b0;
      end
      if (wr && addr == mpo_pkg::OFS_DT_ADC_OPT)
        r_opt2 <= run ? {wdata[7], r_opt2[6], wdata[5:0]} : wdata;
    end
  end

  always @(negedge clk) begin
    if (!rst) begin
      `CHK("crest_out", e_crest, o_crest)
      `CHK("valley_out", e_valley, o_valley)
      `CHK("transfer", e_xfer, o_xfer)
      `CHK("adc_trig", e_adc, o_adc)
      if (!r_opt2[6]) `CHK("dt_down", 3'h0, dt_down)
      if (dt_down[0]) dn_seen++;
      if (dt_busy[0]) bl++;
      else if (bl != 0) begin
        // a window cut short by stopping the timer is not a full dead time
        if (wid > 5'h04 && run) `CHK("busy_len", 1'b1, bl >= int'(dtc) && bl <= int'(dtc) + 2)
        bl = 0;
      end
    end
  end

  // ****************************************************************
  // bus tasks and closing
  // ****************************************************************
  task automatic bus_wr(input logic [27:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [27:0] a, input logic [7:0] ex, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(nm, ex, rdata)
  endtask
  // dead-time compare and mode are only touched with the timer stopped
  task automatic cfg(input logic [7:0] c, input logic [7:0] o, input logic [4:0] w,
                     input logic [9:0] d, input int n);
    @(posedge clk);
    run <= 1'b0;
    bus_wr(mpo_pkg::OFS_CULL_OPT, c);
    bus_wr(mpo_pkg::OFS_DT_ADC_OPT, o);
    wid <= w;
    dtc <= d;
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 12000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    {rst, wr, rd, run, rms} = 5'h10;
    {addr, wdata} = 36'h0;
    dtc = 10'h005;
    wid = 5'h08;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(mpo_pkg::OFS_CULL_OPT, mpo_pkg::RST_CULL_OPT, "cull_rst");
    rd_chk(mpo_pkg::OFS_DT_ADC_OPT, mpo_pkg::RST_DT_ADC_OPT, "opt2_rst");
    bus_wr(mpo_pkg::OFS_CULL_OPT, 8'hFF);
    rd_chk(mpo_pkg::OFS_CULL_OPT, mpo_pkg::CULL_OPT_MASK, "cull_rw");
    bus_wr(28'hFFFF622, 8'hAA);
    rd_chk(28'hFFFF622, mpo_pkg::RD_IDLE, "unmapped");
    @(negedge clk);
    `CHK("rd_idle", mpo_pkg::RD_IDLE, rdata)
    bus_wr(mpo_pkg::OFS_DT_ADC_OPT, 8'hA5);
    rd_chk(mpo_pkg::OFS_DT_ADC_OPT, 8'hA5, "opt2_rw");
    rd_chk(mpo_pkg::OFS_CULL_OPT, mpo_pkg::CULL_OPT_MASK, "cull_keep");
    for (int i = 0; i < 8; i++) begin
      cfg(t_cull[i], t_opt2[i], (i == 7) ? 5'd1 : 5'd8, (i == 7) ? 10'd10 : 10'd5, 800);
    end
    // writes while running: batch first, then anytime
    cfg(8'hC0, 8'h80, 5'd8, 10'd5, 50);
    bus_wr(mpo_pkg::OFS_CULL_OPT, 8'hC2);
    rd_chk(mpo_pkg::OFS_CULL_OPT, 8'hC2, "cull_batch");
    repeat (200) @(posedge clk);
    rms <= 1'b1;
    bus_wr(mpo_pkg::OFS_CULL_OPT, 8'hC1);
    repeat (200) @(posedge clk);
    rms <= 1'b0;
    bus_wr(mpo_pkg::OFS_DT_ADC_OPT, 8'hC1);
    rd_chk(mpo_pkg::OFS_DT_ADC_OPT, 8'h81, "dt_mode_run");
    // recovery from a stray mode change: stop the timer, then program the bit
    cfg(8'hC0, 8'h40, 5'd1, 10'd10, 10);
    rd_chk(mpo_pkg::OFS_DT_ADC_OPT, 8'h40, "dt_mode_stop");
    bus_wr(mpo_pkg::OFS_DT_ADC_OPT, 8'h41);
    rd_chk(mpo_pkg::OFS_DT_ADC_OPT, 8'h41, "dt_mode_same");
    repeat (300) @(posedge clk);
    `CHK("dt_down_seen", 1'b1, dn_seen > 0)
    stop_test();
  end
endmodule
